// file: rtl/uhbp_device.sv
// Device end: bus pins synchronised, strobe edges decoded, register file.
// Also drives the interrupt pin and reports bus style and duplex.
// Assumes pins from the host are asynchronous to sys_clk_in.
// Assumes the host holds select, address and data across each strobe.
`timescale 1ns/100ps
`default_nettype none
// Function
// RQ1 - Write strobe rise loads data into register
// RQ2 - Host drives direction: high read, low write
// RQ3 - Host drops chip select in strobe mode
// RQ4 - Direction mode: select pin is chip select
// RQ5 - Strobe mode: interrupt high, enabled by bit3
// RQ6 - Direction mode: open-drain low, bit3 zero
// RQ7 - Duplex input high half, low full
// RQ8 - Bus select high strobe, low direction
// RQ9 - Read strobe fall drives addressed byte out
// RQ10 - Three address lines pick one register
// RQ11 - Host holds select, address, data across strobe
module uhbp_device (
  input  wire logic sys_clk_in,          // System clock
  input  wire logic rst_in,              // Async reset, active high
  uhbp_if.device    bus,                 // Host bus pins
  input  wire logic irq_event_in,        // Internal interrupt request
  output logic      half_duplex_out,     // Serial line half duplex
  output logic      strobe_mode_out,     // Bus style in use
  output logic      wr_pulse_out,        // One-cycle write done
  output logic [2:0] wr_addr_out,        // Address of last write
  output logic [7:0] wr_data_out         // Data of last write
);
  // All device state in one record
  // Pin stages come first, then the visible state
  typedef struct packed {
    // Pin synchronisers and edge history
    logic [2:0]      s1;       // First sync stage: sel,rd,wr
    logic [2:0]      s2;       // Second sync stage
    logic [2:0]      s3;       // Previous synced value
    logic [1:0]      m1;       // Mode, duplex first stage
    logic [1:0]      m2;       // Mode, duplex synced
    logic [2:0]      a1;       // Address first stage
    logic [2:0]      a2;       // Address synced
    logic [7:0]      d1;       // Write data first stage
    logic [7:0]      d2;       // Write data synced
    logic            e1;       // Interrupt event first stage
    logic            e2;       // Interrupt event synced
    // Register file and read drive
    logic [7:0][7:0] regs;     // Internal registers
    logic [7:0]      dout;     // Read byte on the bus
    logic            doe;      // Read byte driven
    // Interrupt pin
    logic            irq;      // Pin level
    logic            irq_oe;   // Pin driven
    // Status towards the core
    logic            half;     // Half duplex selected
    logic            smode;    // Strobe style selected
    logic            wp;       // Write commit pulse
    logic [2:0]      wa;       // Write address held
    logic [7:0]      wd;       // Write data held
  } uhbp_dev_s;
  uhbp_dev_s  st_reg, st_next;
  logic       sel_n, rd_n, wr_n;       // Synced pin levels
  logic       p_sel_n, p_rd_n, p_wr_n; // Levels one cycle earlier
  logic       rd_act, wr_act, wr_done;
  logic       rd_start, rd_end;
  logic [7:0] rd_byte;                 // Addressed register byte
  logic       irq_en;                  // Modem control interrupt bit
  logic [7:0] reg_we;                  // Write enable per register

  // Decode synced pins per bus style
  // Edges come from synced levels only, so a glitch
  // shorter than a cycle starts an access only if a clock edge samples it
  always_comb begin
    sel_n   = st_reg.s2[2];
    rd_n    = st_reg.s2[1];
    wr_n    = st_reg.s2[0];
    p_sel_n = st_reg.s3[2];
    p_rd_n  = st_reg.s3[1];
    p_wr_n  = st_reg.s3[0];
    if (st_reg.m2[1]) begin                                   // RQ8
      rd_act  = !sel_n && !rd_n;                              // RQ9 RQ3
      wr_act  = !sel_n && !wr_n;                              // RQ1 RQ3
      wr_done = !p_sel_n && !p_wr_n && wr_n;                  // RQ1
      rd_start = rd_act && (p_rd_n || p_sel_n);
      rd_end   = !rd_act;
    end else begin
      rd_act  = !sel_n && wr_n;                               // RQ2 RQ4
      wr_act  = !sel_n && !wr_n;                              // RQ2 RQ4
      wr_done = !p_sel_n && !p_wr_n && sel_n;                 // RQ4 RQ11
      rd_start = rd_act && p_sel_n;
      rd_end   = !rd_act;
    end
  end

  // Three address lines pick one register byte
  always_comb begin
    case (st_reg.a2)                                          // RQ10
      3'h0:    rd_byte = st_reg.regs[0];
      3'h1:    rd_byte = st_reg.regs[1];
      3'h2:    rd_byte = st_reg.regs[2];
      3'h3:    rd_byte = st_reg.regs[3];
      3'h4:    rd_byte = st_reg.regs[4];
      3'h5:    rd_byte = st_reg.regs[5];
      3'h6:    rd_byte = st_reg.regs[6];
      3'h7:    rd_byte = st_reg.regs[7];
      default: rd_byte = uhbp_pkg::DATA_IDLE_VALUE;
    endcase
    irq_en = st_reg.regs[uhbp_pkg::MODEM_CTRL_ADDR]
                        [uhbp_pkg::MODEM_CTRL_IRQ_EN_BIT];
  end

  // One write enable per register from the held address
  for (genvar g = 0; g < uhbp_pkg::NUM_REGS; g++) begin : g_we
    assign reg_we[g] = wr_done && (st_reg.wa == 3'(g));       // RQ10
  end

  // Next-state of all device state
  always_comb begin
    st_next    = st_reg;
    st_next.wp = 1'b0;

    // Two flip-flops on every pin before use
    st_next.s1 = {bus.channel_select_n, bus.read_strobe_n,
                  bus.write_strobe_n};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.m1 = {bus.bus_select, bus.half_duplex_sel};
    st_next.m2 = st_reg.m1;
    st_next.a1 = bus.addr;
    st_next.a2 = st_reg.a1;
    st_next.d1 = bus.data_host;
    st_next.d2 = st_reg.d1;
    st_next.e1 = irq_event_in;
    st_next.e2 = st_reg.e1;

    // Bus style and duplex follow the synced pins
    st_next.half  = st_reg.m2[0];                             // RQ7
    st_next.smode = st_reg.m2[1];                             // RQ8

    // Latch write data while active, commit on the closing edge
    // Data is taken while the strobe is low, so a bus that moves
    // just after the closing edge cannot corrupt the byte
    if (wr_act) begin
      st_next.wa = st_reg.a2;                                 // RQ10
      st_next.wd = st_reg.d2;
    end
    for (int i = 0; i < uhbp_pkg::NUM_REGS; i++) begin
      if (reg_we[i]) begin
        st_next.regs[i] = st_reg.wd;                          // RQ1
      end
    end
    if (wr_done) begin
      st_next.wp = 1'b1;
    end

    // Read drive from strobe fall to strobe end
    if (rd_start) begin
      st_next.dout = rd_byte;                                 // RQ9 RQ10
      st_next.doe  = 1'b1;
    end else if (rd_end) begin
      st_next.doe  = 1'b0;
      st_next.dout = uhbp_pkg::DATA_IDLE_VALUE;
    end

    // Interrupt pin per bus style
    // Strobe style drives the event level while bit3 is set, else floats; direction style
    // only pulls low and leaves the high level to a pull-up
    if (st_reg.m2[1]) begin
      st_next.irq    = st_reg.e2;                             // RQ5
      st_next.irq_oe = irq_en;                                // RQ5
    end else begin
      st_next.irq    = 1'b0;                                  // RQ6
      st_next.irq_oe = st_reg.e2 && !irq_en;                  // RQ6
    end
  end

  // State register
  // Pin stages reset to the idle pin levels so that
  // no false strobe edge follows reset
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      // Pin stages at idle levels
      st_reg.s1     <= 3'h7;
      st_reg.s2     <= 3'h7;
      st_reg.s3     <= 3'h7;
      st_reg.m1     <= 2'h2;
      st_reg.m2     <= 2'h2;
      st_reg.a1     <= 3'h0;
      st_reg.a2     <= 3'h0;
      st_reg.d1     <= 8'h00;
      st_reg.d2     <= 8'h00;
      st_reg.e1     <= 1'b0;
      st_reg.e2     <= 1'b0;
      // Registers cleared, bus released
      st_reg.regs   <= '0;
      st_reg.dout   <= uhbp_pkg::DATA_IDLE_VALUE;
      st_reg.doe    <= 1'b0;
      // Interrupt pin released
      st_reg.irq    <= 1'b0;
      st_reg.irq_oe <= 1'b0;
      // Core status cleared
      st_reg.half   <= 1'b0;
      st_reg.smode  <= 1'b0;
      st_reg.wp     <= 1'b0;
      st_reg.wa     <= 3'h0;
      st_reg.wd     <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  // Bus pins straight from the state register
  assign bus.data_dev           = st_reg.dout;
  assign bus.data_dev_oe        = st_reg.doe;
  assign bus.interrupt_out_high = st_reg.irq;
  assign bus.interrupt_oe       = st_reg.irq_oe;

  // Status towards the core
  assign half_duplex_out        = st_reg.half;
  assign strobe_mode_out        = st_reg.smode;
  assign wr_pulse_out           = st_reg.wp;
  assign wr_addr_out            = st_reg.wa;
  assign wr_data_out            = st_reg.wd;
endmodule : uhbp_device
`default_nettype wire

// file: rtl/uhbp_pkg.sv
// Package for the host bus port: register select width, modes, constants.
// Assumes both ends run on one 100 MHz clock.
package uhbp_pkg;
  localparam int          ADDR_W          = 3;
  localparam int          DATA_W          = 8;
  localparam int          NUM_REGS        = 8;
  localparam int          MODEM_CTRL_ADDR       = 4;
  localparam int          MODEM_CTRL_IRQ_EN_BIT = 3;
  localparam logic [7:0]  REG_RESET_VALUE = 8'h00;
  localparam logic [7:0]  DATA_IDLE_VALUE = 8'h00;
  // Host strobe low time and setup/hold in cycles
  localparam int          STROBE_NS       = 40;
  localparam int          CLK_NS          = 10;
  localparam logic [3:0]  STROBE_CYCLES   = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  SETUP_CYCLES    = 4'h2;
  typedef enum logic [0:0] {UHBP_MODE_DIR, UHBP_MODE_STROBE} uhbp_mode_e;
  typedef enum {UHBP_IDLE, UHBP_SETUP, UHBP_LOW, UHBP_HOLD} uhbp_hstate_e;
endpackage : uhbp_pkg

// file: rtl/uhbp_if.sv
// Interface joining host and device ends of the parallel port.
// Assumes the testbench resolves the data bus and interrupt wire.
`timescale 1ns/100ps
`default_nettype none
interface uhbp_if;
  logic       bus_select;          // High strobe style, low direction line
  logic       channel_select_n;    // Chip select, active low
  logic       read_strobe_n;       // Read strobe, strobe style only
  logic       write_strobe_n;      // Write strobe or direction (high=read)
  logic [2:0] addr;                // Register select, msb is bit 2
  logic [7:0] data_host;           // Data driven by host
  logic       data_host_oe;        // Host drives data
  logic [7:0] data_dev;            // Data driven by device
  logic       data_dev_oe;         // Device drives data
  logic       interrupt_out_high;  // Interrupt pin level from device
  logic       interrupt_oe;        // Device drives interrupt pin
  logic       half_duplex_sel;     // Duplex select, high=half
  modport device (input bus_select, channel_select_n, read_strobe_n,
                  write_strobe_n, addr, data_host, data_host_oe,
                  half_duplex_sel,
                  output data_dev, data_dev_oe, interrupt_out_high,
                  interrupt_oe);
  modport host (output bus_select, channel_select_n, read_strobe_n,
                write_strobe_n, addr, data_host, data_host_oe,
                half_duplex_sel,
                input data_dev, data_dev_oe, interrupt_out_high,
                interrupt_oe);
endinterface : uhbp_if
`default_nettype wire

// file: rtl/uhbp_host.sv
// Host end: runs one read or write access in the selected bus style.
// Assumes the device samples pins through two-stage synchronisers.
`timescale 1ns/100ps
`default_nettype none
module uhbp_host (
  input  wire logic       sys_clk_in,     // System clock
  input  wire logic       rst_in,         // Async reset, active high
  uhbp_if.host            bus,            // Device bus pins
  input  wire logic       strobe_mode_in, // Bus style: 1 strobe
  input  wire logic       half_duplex_in, // Duplex request
  input  wire logic       req_in,         // Access request pulse
  input  wire logic       req_write_in,   // 1 write, 0 read
  input  wire logic [2:0] req_addr_in,    // Register select
  input  wire logic [7:0] req_data_in,    // Write data
  output logic            busy_out,       // Access in progress
  output logic            done_out,       // One-cycle completion
  output logic [7:0]      rd_data_out,    // Read data
  output logic            irq_out         // Interrupt seen, level
);
  typedef struct packed {
    uhbp_pkg::uhbp_hstate_e fsm;
    logic [3:0] cnt;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       smode;
    logic       half;
    logic       sel_n;
    logic       rd_n;
    logic       wr_n;
    logic       doe;
    logic       busy;
    logic       done;
    logic [7:0] rdata;
    logic [1:0] iq1;
    logic [1:0] iq2;
    logic [7:0] dq1;
    logic [7:0] dq2;
    logic       irq;
  } uhbp_host_s;
  uhbp_host_s st_reg, st_next;

  // Access sequencer
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    st_next.iq1  = {bus.interrupt_out_high, bus.interrupt_oe};
    st_next.iq2  = st_reg.iq1;
    st_next.dq1  = bus.data_dev;
    st_next.dq2  = st_reg.dq1;
    // Strobe style: driven high; direction style: open drain low
    st_next.irq  = st_reg.smode ? (st_reg.iq2[0] && st_reg.iq2[1])
                                : st_reg.iq2[0];                // RQ5 RQ6
    case (st_reg.fsm)
      uhbp_pkg::UHBP_IDLE: begin
        if (req_in) begin
          st_next.fsm   = uhbp_pkg::UHBP_SETUP;
          st_next.cnt   = uhbp_pkg::SETUP_CYCLES;
          st_next.wr    = req_write_in;
          st_next.addr  = req_addr_in;
          st_next.wdata = req_data_in;
          st_next.smode = strobe_mode_in;
          st_next.half  = half_duplex_in;
          st_next.busy  = 1'b1;
          st_next.sel_n = 1'b0;                                 // RQ3 RQ4
          st_next.doe   = req_write_in;
          st_next.wr_n  = strobe_mode_in ? 1'b1 : !req_write_in; // RQ2
        end
      end
      uhbp_pkg::UHBP_SETUP: begin
        st_next.cnt = st_reg.cnt - 4'h1;
        if (st_reg.cnt == 4'h1) begin
          st_next.fsm = uhbp_pkg::UHBP_LOW;
          st_next.cnt = uhbp_pkg::STROBE_CYCLES + uhbp_pkg::SETUP_CYCLES;
          if (st_reg.smode) begin
            st_next.wr_n = !st_reg.wr;                          // RQ1
            st_next.rd_n = st_reg.wr;                           // RQ9
          end
        end
      end
      uhbp_pkg::UHBP_LOW: begin
        st_next.cnt = st_reg.cnt - 4'h1;
        if (st_reg.cnt == 4'h1) begin
          st_next.fsm   = uhbp_pkg::UHBP_HOLD;
          st_next.cnt   = uhbp_pkg::SETUP_CYCLES;
          st_next.rdata = st_reg.dq2;
          if (st_reg.smode) begin
            st_next.wr_n = 1'b1;
            st_next.rd_n = 1'b1;
          end else begin
            st_next.sel_n = 1'b1;
          end
        end
      end
      uhbp_pkg::UHBP_HOLD: begin
        st_next.cnt = st_reg.cnt - 4'h1;                        // RQ11
        if (st_reg.cnt == 4'h1) begin
          st_next.fsm   = uhbp_pkg::UHBP_IDLE;
          st_next.sel_n = 1'b1;
          st_next.wr_n  = 1'b1;
          st_next.doe   = 1'b0;
          st_next.busy  = 1'b0;
          st_next.done  = 1'b1;
        end
      end
      default: st_next.fsm = uhbp_pkg::UHBP_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg       <= '0;
      st_reg.fsm   <= uhbp_pkg::UHBP_IDLE;
      st_reg.sel_n <= 1'b1;
      st_reg.rd_n  <= 1'b1;
      st_reg.wr_n  <= 1'b1;
      st_reg.smode <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.bus_select       = st_reg.smode;
  assign bus.half_duplex_sel  = st_reg.half;
  assign bus.channel_select_n = st_reg.sel_n;
  assign bus.read_strobe_n    = st_reg.rd_n;
  assign bus.write_strobe_n   = st_reg.wr_n;
  assign bus.addr             = st_reg.addr;
  assign bus.data_host        = st_reg.wdata;
  assign bus.data_host_oe     = st_reg.doe;
  assign busy_out             = st_reg.busy;
  assign done_out             = st_reg.done;
  assign rd_data_out          = st_reg.rdata;
  assign irq_out              = st_reg.irq;
endmodule : uhbp_host
`default_nettype wire

// file: verification/uhbp_props.sv
// Checker on the wires between the host and device ends of the port.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module uhbp_props (
  input wire logic       sys_clk_in,         // System clock
  input wire logic       rst_in,             // Reset, active high
  input wire logic       bus_select,         // 1 strobe style
  input wire logic       channel_select_n,   // Chip select
  input wire logic       read_strobe_n,      // Read strobe
  input wire logic       write_strobe_n,     // Write strobe or direction
  input wire logic [2:0] addr,               // Register select
  input wire logic [7:0] data_host,          // Host data
  input wire logic       data_host_oe,       // Host drives data
  input wire logic       data_dev_oe,        // Device drives data
  input wire logic       interrupt_out_high, // Interrupt level
  input wire logic       interrupt_oe        // Interrupt driven
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Strobe style access framing, data contention in both styles
  a_wr_strobe_sel: assert property (
    bus_select && $fell(write_strobe_n) |-> !channel_select_n)
    else $error("write strobe fell while deselected");
  a_strobe_hold: assert property (
    bus_select && !write_strobe_n && !$past(write_strobe_n)
    |-> $stable(addr) && $stable(data_host) && !channel_select_n)
    else $error("address or data moved under write strobe");
  a_rd_drive: assert property (
    bus_select && !channel_select_n && $fell(read_strobe_n)
    |-> ##[3:4] data_dev_oe)
    else $error("read data not driven after read strobe");
  a_rd_release: assert property (
    bus_select && $rose(read_strobe_n) |-> ##[3:4] !data_dev_oe)
    else $error("read data not released");
  a_no_contend: assert property (!(data_dev_oe && data_host_oe))
    else $error("both ends drive data");
  // Direction line style
  a_dir_stable: assert property (
    !bus_select && !channel_select_n && !$past(channel_select_n)
    |-> $stable(write_strobe_n) && $stable(addr))
    else $error("direction moved while selected");
  a_dir_rd_drive: assert property (
    !bus_select && $fell(channel_select_n) && write_strobe_n
    |-> ##[3:4] data_dev_oe)
    else $error("direction read not driven");
  a_dir_wr_quiet: assert property (
    !bus_select && $fell(channel_select_n) && !write_strobe_n
    |-> ##4 !data_dev_oe [*4])
    else $error("device drove data on a write");
  a_dir_irq_low: assert property (
    !bus_select && !$past(bus_select, 4) && interrupt_oe
    |-> !interrupt_out_high)
    else $error("direction style interrupt not driven low");
  // Main scenarios seen
  c_wr: cover property (bus_select && $rose(write_strobe_n));
  c_dir_rd: cover property (!bus_select && data_dev_oe);
  c_irq: cover property (interrupt_oe && interrupt_out_high);
endmodule // uhbp_props
`default_nettype wire

// file: verification/uart_host_bus_port_tb.sv
// Testbench joining host and device ends across the bus interface.
// Assumes a 100 MHz clock and the access timing of the host end.
`timescale 1ns/100ps
`default_nettype none
module uart_host_bus_port_tb;
  logic       clk, rst, irq_ev, mode, half, req, req_w;
  logic [2:0] req_a, wr_a;
  logic [7:0] req_d, rd_data, wr_d;
  logic       busy, done, irq, half_o, mode_o, wr_p;
  int         err_total, n_tests;
  uhbp_if bus_if ();
  uhbp_device u_uhbp_device (.sys_clk_in(clk), .rst_in(rst), .bus(bus_if),
    .irq_event_in(irq_ev), .half_duplex_out(half_o),
    .strobe_mode_out(mode_o), .wr_pulse_out(wr_p), .wr_addr_out(wr_a),
    .wr_data_out(wr_d));
  uhbp_host u_uhbp_host (.sys_clk_in(clk), .rst_in(rst), .bus(bus_if),
    .strobe_mode_in(mode), .half_duplex_in(half), .req_in(req),
    .req_write_in(req_w), .req_addr_in(req_a), .req_data_in(req_d),
    .busy_out(busy), .done_out(done), .rd_data_out(rd_data),
    .irq_out(irq));
  uhbp_props u_uhbp_props (.sys_clk_in(clk), .rst_in(rst),
    .bus_select(bus_if.bus_select),
    .channel_select_n(bus_if.channel_select_n),
    .read_strobe_n(bus_if.read_strobe_n),
    .write_strobe_n(bus_if.write_strobe_n), .addr(bus_if.addr),
    .data_host(bus_if.data_host), .data_host_oe(bus_if.data_host_oe),
    .data_dev_oe(bus_if.data_dev_oe),
    .interrupt_out_high(bus_if.interrupt_out_high),
    .interrupt_oe(bus_if.interrupt_oe));
  // Compare one result and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One access; a write also waits for the device commit pulse
  task automatic acc(input logic m, input logic w, input logic [2:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    mode <= m;
    req <= 1'b1;
    req_w <= w;
    req_a <= a;
    req_d <= d;
    @(posedge clk);
    req <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 40);
    while (w && wr_p !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, n < 40}, 8'h01);
  endtask
  // Strobe style: fill every register, read each back
  task automatic t_strobe_rw();
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, 1'b1, 3'(i), 8'hC0 | 8'(i));
      chk({5'h0, wr_a}, 8'(i));
      chk(wr_d, 8'hC0 | 8'(i));
    end
    for (int i = 7; i >= 0; i--) begin
      acc(1'b1, 1'b0, 3'(i), 8'h00);
      chk(rd_data, 8'hC0 | 8'(i));
    end
    chk({7'h0, mode_o}, 8'h01);
    $display("test strobe_rw done");
  endtask
  // Direction style write and reads
  task automatic t_dir_rw();
    acc(1'b0, 1'b1, 3'h5, 8'h5A);
    chk({5'h0, wr_a}, 8'h05);
    chk(wr_d, 8'h5A);
    acc(1'b0, 1'b0, 3'h2, 8'h00);
    chk(rd_data, 8'hC2);
    acc(1'b0, 1'b0, 3'h5, 8'h00);
    chk(rd_data, 8'h5A);
    chk({7'h0, mode_o}, 8'h00);
    $display("test dir_rw done");
  endtask
  // Interrupt pin: strobe style enabled and disabled, direction style enabled
  task automatic t_irq();
    acc(1'b1, 1'b1, 3'h4, 8'h08);
    @(posedge clk);
    irq_ev <= 1'b1;
    repeat (8) @(negedge clk);
    chk({6'h0, bus_if.interrupt_oe, bus_if.interrupt_out_high}, 8'h03);
    chk({7'h0, irq}, 8'h01);
    acc(1'b1, 1'b1, 3'h4, 8'h00);
    repeat (6) @(negedge clk);
    chk({7'h0, bus_if.interrupt_oe}, 8'h00);
    acc(1'b0, 1'b0, 3'h4, 8'h00);
    repeat (6) @(negedge clk);
    chk({6'h0, bus_if.interrupt_oe, bus_if.interrupt_out_high}, 8'h02);
    chk({7'h0, irq}, 8'h01);
    @(posedge clk);
    irq_ev <= 1'b0;
    repeat (6) @(negedge clk);
    chk({7'h0, bus_if.interrupt_oe}, 8'h00);
    $display("test irq done");
  endtask
  // Duplex select high then low
  task automatic t_duplex();
    for (int i = 1; i >= 0; i--) begin
      @(posedge clk);
      half <= 1'(i);
      acc(1'b1, 1'b0, 3'h0, 8'h00);
      repeat (4) @(negedge clk);
      chk({7'h0, half_o}, 8'(i));
    end
    $display("test duplex done");
  endtask
  // Counts and verdict
  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Reset, then the scenarios
  initial begin
    {rst, mode, irq_ev, half, req, req_w} = 6'h30;
    req_a = 3'h0;
    req_d = 8'h00;
    err_total = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_strobe_rw();
    t_dir_rw();
    t_irq();
    t_duplex();
    stop_test();
  end
  // Watchdog
  initial begin
    #50000;
    err_total++;
    stop_test();
  end
endmodule // uart_host_bus_port_tb
`default_nettype wire
